// >>> rtl/asr_cfg.svh
// Register indices, field positions, reset values and counts for the converter sequencer
`ifndef ASR_CFG_SVH
`define ASR_CFG_SVH

`define ASR_IDX_FILTER 10'h094
`define ASR_IDX_ACC 10'h096
`define ASR_IDX_CNT 10'h099
`define ASR_IDX_RPT 10'h09a
`define ASR_IDX_RES 10'h09d
`define ASR_IDX_PCH 10'h09f
`define ASR_IDX_ACQ 10'h10c
`define ASR_IDX_CAP 10'h10e
`define ASR_IDX_PRE 10'h10f
`define ASR_IDX_CTRL 10'h110
`define ASR_IDX_STAT 10'h111

`define ASR_CTRL_MODE 2:0
`define ASR_CTRL_CLEAR 3
`define ASR_CTRL_SHIFT 6:4
`define ASR_CTRL_JUSTIFY 7
`define ASR_CTRL_REF 9:8
`define ASR_CTRL_CLKSEL 15:10
`define ASR_CTRL_GO 16
`define ASR_STAT_THR 4

`define ASR_MODE_BASIC 3'h0
`define ASR_MODE_ACCUM 3'h1
`define ASR_MODE_AVG 3'h2
`define ASR_MODE_BURST 3'h3
`define ASR_MODE_LPF 3'h4

`define ASR_REF_SUPPLY 2'h0
`define ASR_REF_PIN 2'h2
`define ASR_REF_FIXED 2'h3

`define ASR_ACQ_DEFAULT 14'h2000
`define ASR_CNT_MAX 8'hff

`endif

// >>> rtl/asr_pkg.sv
// Types shared by the converter sequencer
package asr_pkg;
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_PRE,
        ST_ACQ,
        ST_CONV,
        ST_DONE
    } asr_state_e;
    typedef logic [2:0] asr_mode_t;
endpackage

// >>> rtl/asr_adc_sequencer.sv
// Converter sequencer, computation and result registers with APB slave
`timescale 1ns/10ps
`include "asr_cfg.svh"

// Summary of operation
// [R1] Reference code picks fixed, pin or supply
// [R2] Six-bit input channel select, reset zero
// [R3] Nonzero precharge lasts that many converter clocks
// [R4] Zero precharge setting skips precharge phase
// [R5] Nonzero acquisition lasts that many converter clocks
// [R6] Both settings zero omits acquisition phase
// [R7] Zero acquisition after precharge lasts 8192 clocks
// [R8] Extra capacitance setting drives sample capacitors
// [R9] Repeat counter counts converter triggers in the four modes other than basic
// [R10] Threshold check when counter reaches threshold
// [R11] Counter and result survive non-power-on resets
// [R12] Filter output is accumulator shifted right
// [R13] Low-pass mode outputs filter computation
// [R14] Right justify: high byte top four bits
// [R15] Left justify: low nibble zero
// [R16] Mode field selects five computation modes
// [R17] Clear command clears accumulator, overflow, counter
// [R18] Shift setting divides accumulated value
// [R19] Precharge, then acquisition, then conversion
module asr_adc_sequencer (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic [11:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Analog core
    output logic [1:0] upper_reference_select,
    output logic ref_to_fixed_voltage_reference,
    output logic ref_to_pin,
    output logic ref_to_supply,
    output logic [5:0] input_channel_select,
    output logic [4:0] extra_capacitance_setting,
    output logic precharge_active,
    output logic acquire_active,
    output logic conv_req,
    input wire logic conv_valid,
    input wire logic [11:0] conv_data
);

    logic [9:0] idx;
    logic addr_ok;
    logic wr;
    logic hit;
    logic [31:0] rd_data;

    logic [12:0] precharge_time;
    logic [12:0] acquisition_time;
    logic [7:0] repeat_threshold;
    logic [2:0] accumulator_shift;
    logic result_justify;
    logic accumulator_clear_command;
    logic [5:0] clk_sel;
    logic go;
    asr_pkg::asr_mode_t computation_mode;

    asr_pkg::asr_state_e state;
    logic [13:0] phase_cnt;
    logic [6:0] div;
    logic tick;
    logic [11:0] sample;
    logic done;

    logic [17:0] accumulator;
    logic overflow;
    logic thr_hit;
    logic [15:0] filter_output;
    logic [15:0] conversion_result;
    logic [7:0] repeat_counter;

    logic active_mode;
    logic low_pass_filter_mode;
    logic restart;
    logic [17:0] base_acc;
    logic [7:0] base_cnt;
    logic [18:0] next_sum;
    logic [7:0] next_cnt;

    // Bus decode
    assign idx = paddr[11:2];
    assign addr_ok = (paddr[1:0] == 2'h0);
    assign wr = psel && penable && pwrite && hit;
    assign pready = 1'b1;

    always_comb begin
        hit = addr_ok;
        rd_data = 32'h0;
        case (idx)
            `ASR_IDX_FILTER: rd_data = {16'h0, filter_output};
            `ASR_IDX_ACC: rd_data = {14'h0, accumulator};
            `ASR_IDX_CNT: rd_data = {24'h0, repeat_counter};
            `ASR_IDX_RPT: rd_data = {24'h0, repeat_threshold};
            `ASR_IDX_RES: rd_data = {16'h0, conversion_result};
            `ASR_IDX_PCH: rd_data = {26'h0, input_channel_select};
            `ASR_IDX_ACQ: rd_data = {19'h0, acquisition_time};
            `ASR_IDX_CAP: rd_data = {27'h0, extra_capacitance_setting};
            `ASR_IDX_PRE: rd_data = {19'h0, precharge_time};
            `ASR_IDX_CTRL: begin
                rd_data = {15'h0, go, clk_sel, upper_reference_select, result_justify,
                           accumulator_shift, accumulator_clear_command, computation_mode};
            end
            `ASR_IDX_STAT: begin
                rd_data = {27'h0, thr_hit, overflow, 3'(state)};
            end
            default: hit = 1'b0;
        endcase
    end

    // Read data and error are captured in the setup cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0;
            pslverr <= 1'b0;
        end else if (psel && !penable) begin
            prdata <= hit ? rd_data : 32'h0;
            pslverr <= !hit;
        end
    end

    // Configuration registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            precharge_time <= 13'h0;
            acquisition_time <= 13'h0;
            repeat_threshold <= 8'h0;
            input_channel_select <= 6'h0;
            extra_capacitance_setting <= 5'h0;
            upper_reference_select <= `ASR_REF_SUPPLY;
            computation_mode <= `ASR_MODE_BASIC;
            accumulator_shift <= 3'h0;
            result_justify <= 1'b0;
            clk_sel <= 6'h0;
        end else if (wr) begin
            case (idx)
                `ASR_IDX_PRE: precharge_time <= pwdata[12:0];
                `ASR_IDX_ACQ: acquisition_time <= pwdata[12:0];
                `ASR_IDX_RPT: repeat_threshold <= pwdata[7:0];
                `ASR_IDX_PCH: input_channel_select <= pwdata[5:0]; // [R2]
                `ASR_IDX_CAP: extra_capacitance_setting <= pwdata[4:0]; // [R8]
                `ASR_IDX_CTRL: begin
                    upper_reference_select <= pwdata[`ASR_CTRL_REF];
                    computation_mode <= pwdata[`ASR_CTRL_MODE]; // [R16]
                    accumulator_shift <= pwdata[`ASR_CTRL_SHIFT];
                    result_justify <= pwdata[`ASR_CTRL_JUSTIFY];
                    clk_sel <= pwdata[`ASR_CTRL_CLKSEL];
                end
                default: begin
                end
            endcase
        end
    end

    // Start bit, cleared by hardware at the end of a conversion
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            go <= 1'b0;
        end else if (wr && idx == `ASR_IDX_CTRL) begin
            go <= pwdata[`ASR_CTRL_GO];
        end else if (done) begin
            go <= 1'b0;
        end
    end

    // Clear command, self-clearing after one cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            accumulator_clear_command <= 1'b0;
        end else if (wr && idx == `ASR_IDX_CTRL) begin
            accumulator_clear_command <= pwdata[`ASR_CTRL_CLEAR];
        end else if (accumulator_clear_command) begin
            accumulator_clear_command <= 1'b0; // [R17]
        end
    end

    // Reference routing
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ref_to_fixed_voltage_reference <= 1'b0;
            ref_to_pin <= 1'b0;
            ref_to_supply <= 1'b1;
        end else begin
            ref_to_fixed_voltage_reference <= (upper_reference_select == `ASR_REF_FIXED); // [R1]
            ref_to_pin <= (upper_reference_select == `ASR_REF_PIN); // [R1]
            ref_to_supply <= (upper_reference_select == `ASR_REF_SUPPLY); // [R1]
        end
    end

    // Converter clock divider: period of 2*(clk_sel+1) bus clocks
    assign tick = (state != asr_pkg::ST_IDLE) && (div == {clk_sel, 1'b1});

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div <= 7'h0;
        end else if (state == asr_pkg::ST_IDLE || tick) begin
            div <= 7'h0;
        end else begin
            div <= div + 7'h1;
        end
    end

    // Conversion sequencer
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state <= asr_pkg::ST_IDLE;
            phase_cnt <= 14'h0;
            sample <= 12'h0;
        end else begin
            case (state)
                asr_pkg::ST_IDLE: begin
                    if (go) begin
                        if (precharge_time != 13'h0) begin
                            state <= asr_pkg::ST_PRE; // [R19]
                            phase_cnt <= {1'b0, precharge_time}; // [R3]
                        end else if (acquisition_time != 13'h0) begin
                            state <= asr_pkg::ST_ACQ; // [R4]
                            phase_cnt <= {1'b0, acquisition_time}; // [R5]
                        end else begin
                            state <= asr_pkg::ST_CONV; // [R6]
                        end
                    end
                end
                asr_pkg::ST_PRE: begin
                    if (tick && phase_cnt == 14'h1) begin
                        state <= asr_pkg::ST_ACQ; // [R19]
                        if (acquisition_time == 13'h0) begin
                            phase_cnt <= `ASR_ACQ_DEFAULT; // [R7]
                        end else begin
                            phase_cnt <= {1'b0, acquisition_time}; // [R5]
                        end
                    end else if (tick) begin
                        phase_cnt <= phase_cnt - 14'h1; // [R3]
                    end
                end
                asr_pkg::ST_ACQ: begin
                    if (tick && phase_cnt == 14'h1) begin
                        state <= asr_pkg::ST_CONV; // [R19]
                    end else if (tick) begin
                        phase_cnt <= phase_cnt - 14'h1; // [R5]
                    end
                end
                asr_pkg::ST_CONV: begin
                    if (conv_valid) begin
                        state <= asr_pkg::ST_DONE;
                        sample <= conv_data;
                    end
                end
                asr_pkg::ST_DONE: begin
                    state <= asr_pkg::ST_IDLE;
                end
                default: state <= asr_pkg::ST_IDLE;
            endcase
        end
    end

    assign done = (state == asr_pkg::ST_DONE);
    assign precharge_active = (state == asr_pkg::ST_PRE);
    assign acquire_active = (state == asr_pkg::ST_ACQ);
    assign conv_req = (state == asr_pkg::ST_CONV);

    // Computation of the next accumulator and count
    assign active_mode = (computation_mode != `ASR_MODE_BASIC) && (computation_mode <= `ASR_MODE_LPF);
    assign low_pass_filter_mode = (computation_mode == `ASR_MODE_LPF);

    always_comb begin
        restart = ((computation_mode == `ASR_MODE_AVG) || (computation_mode == `ASR_MODE_BURST))
                  && (repeat_counter == repeat_threshold);
        base_acc = restart ? 18'h0 : accumulator;
        base_cnt = restart ? 8'h0 : repeat_counter;
        if (low_pass_filter_mode) begin
            next_sum = {1'b0, accumulator} - ({1'b0, accumulator} >> accumulator_shift)
                       + {7'h0, sample}; // [R13]
        end else begin
            next_sum = {1'b0, base_acc} + {7'h0, sample};
        end
        next_cnt = (base_cnt == `ASR_CNT_MAX) ? `ASR_CNT_MAX : base_cnt + 8'h1; // [R9]
    end

    // Accumulator and overflow
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            accumulator <= 18'h0;
            overflow <= 1'b0;
        end else if (accumulator_clear_command) begin
            accumulator <= 18'h0; // [R17]
            overflow <= 1'b0; // [R17]
        end else if (done && active_mode) begin
            accumulator <= next_sum[17:0];
            overflow <= overflow | next_sum[18];
        end else if (wr && idx == `ASR_IDX_ACC) begin
            accumulator <= pwdata[17:0];
        end
    end

    // Filter output
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            filter_output <= 16'h0;
        end else if (done && active_mode) begin
            filter_output <= 16'(next_sum[17:0] >> accumulator_shift); // [R12] [R18]
        end
    end

    // Threshold reached flag: set wins over write-one-to-clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            thr_hit <= 1'b0;
        end else if (done && active_mode && next_cnt == repeat_threshold) begin
            thr_hit <= 1'b1; // [R10]
        end else if (wr && idx == `ASR_IDX_STAT && pwdata[`ASR_STAT_THR]) begin
            thr_hit <= 1'b0;
        end
    end

    // Result register, kept across bus resets
    always_ff @(posedge pclk) begin
        if (done) begin
            if (result_justify) begin
                conversion_result <= {4'h0, sample}; // [R14] [R11]
            end else begin
                conversion_result <= {sample, 4'h0}; // [R15] [R11]
            end
        end else if (wr && idx == `ASR_IDX_RES) begin
            conversion_result <= pwdata[15:0];
        end
    end

    // Repeat counter, kept across bus resets
    always_ff @(posedge pclk) begin
        if (accumulator_clear_command) begin
            repeat_counter <= 8'h0; // [R17] [R11]
        end else if (done && active_mode) begin
            repeat_counter <= next_cnt; // [R9]
        end else if (wr && idx == `ASR_IDX_CNT) begin
            repeat_counter <= pwdata[7:0];
        end
    end

endmodule

// >>> verif/asr_chk.sv
// Assertion checker for the converter sequencer ports
`timescale 1ns/10ps
module asr_chk (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Analog core
    input wire logic [1:0] upper_reference_select,
    input wire logic ref_to_fixed_voltage_reference,
    input wire logic ref_to_pin,
    input wire logic ref_to_supply,
    input wire logic precharge_active,
    input wire logic acquire_active,
    input wire logic conv_req,
    input wire logic conv_valid
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    property p_ref_fixed;
        upper_reference_select == 2'h3 |=> ref_to_fixed_voltage_reference && !ref_to_pin && !ref_to_supply;
    endproperty
    a_ref_fixed: assert property (p_ref_fixed) else $error("fixed reference not selected");
    property p_ref_pin;
        upper_reference_select == 2'h2 |=> ref_to_pin && !ref_to_fixed_voltage_reference && !ref_to_supply;
    endproperty
    a_ref_pin: assert property (p_ref_pin) else $error("pin reference not selected");
    property p_ref_rsvd;
        upper_reference_select == 2'h1 |=> !(ref_to_pin || ref_to_fixed_voltage_reference || ref_to_supply);
    endproperty
    a_ref_rsvd: assert property (p_ref_rsvd) else $error("reserved code drives a reference");
    property p_phase_excl;
        !(precharge_active && acquire_active) && !(conv_req && (precharge_active || acquire_active));
    endproperty
    a_phase_excl: assert property (p_phase_excl) else $error("two phases at once");
    property p_pre_then_acq;
        $fell(precharge_active) |-> acquire_active;
    endproperty
    a_pre_then_acq: assert property (p_pre_then_acq) else $error("precharge not followed by acquisition");
    property p_acq_then_conv;
        $fell(acquire_active) |-> conv_req;
    endproperty
    a_acq_then_conv: assert property (p_acq_then_conv) else $error("acquisition not followed by conversion");
    property p_pre_min;
        $rose(precharge_active) |-> precharge_active [*2];
    endproperty
    a_pre_min: assert property (p_pre_min) else $error("precharge shorter than one tick");
    property p_conv_end;
        conv_req && conv_valid |=> !conv_req [*2];
    endproperty
    a_conv_end: assert property (p_conv_end) else $error("conversion request not dropped");
endmodule

// >>> verif/asr_core_model.sv
// Behavioural model of the analog conversion core
`timescale 1ns/10ps
module asr_core_model (
    // Clock
    input wire logic pclk,
    // Sequencer side
    input wire logic conv_req,
    output logic conv_valid,
    output logic [11:0] conv_data,
    // Bench control
    input wire logic [11:0] sample,
    input wire logic [3:0] delay
);
    logic [3:0] wait_cnt = 4'h0;
    logic valid_q = 1'b0;
    logic [11:0] data_q = 12'h0;
    assign conv_valid = valid_q;
    assign conv_data = data_q;
    // Answers after delay cycles; data toggles while not valid
    always @(posedge pclk) begin
        if (conv_req && !valid_q && wait_cnt >= delay) begin
            valid_q <= 1'b1;
            data_q <= sample;
            wait_cnt <= 4'h0;
        end else begin
            valid_q <= 1'b0;
            data_q <= ~data_q;
            wait_cnt <= conv_req ? wait_cnt + 4'h1 : 4'h0;
        end
    end
endmodule

// >>> verif/testbench.sv
// Self-checking bench for the converter sequencer
`timescale 1ns/10ps
`include "asr_cfg.svh"
`define CHK(nm, e, s) begin n_tests++; if ((s) !== (e)) begin n_errors++; \
$display("MISMATCH %s exp %h got %h", nm, e, s); end end
module testbench;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h0;
    logic [31:0] pwdata = 32'h0;
    logic [11:0] sample = 12'h0;
    logic [3:0] delay = 4'h0;
    logic [31:0] prdata, rd, keep;
    logic pready, pslverr, err, conv_req, conv_valid, precharge_active, acquire_active;
    logic ref_to_fixed_voltage_reference, ref_to_pin, ref_to_supply;
    logic [1:0] upper_reference_select;
    logic [5:0] input_channel_select;
    logic [4:0] extra_capacitance_setting;
    logic [11:0] conv_data;
    int n_errors = 0;
    int n_tests = 0;
    int n_pre, n_acq, acc, s, p, q, c, j;
    logic [9:0] ridx [5] = '{`ASR_IDX_RPT, `ASR_IDX_PCH, `ASR_IDX_ACQ, `ASR_IDX_CAP, `ASR_IDX_PRE};
    asr_adc_sequencer DUT (
        .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .upper_reference_select(upper_reference_select),
        .ref_to_fixed_voltage_reference(ref_to_fixed_voltage_reference), .ref_to_pin(ref_to_pin),
        .ref_to_supply(ref_to_supply), .input_channel_select(input_channel_select),
        .extra_capacitance_setting(extra_capacitance_setting), .precharge_active(precharge_active),
        .acquire_active(acquire_active), .conv_req(conv_req), .conv_valid(conv_valid), .conv_data(conv_data)
    );
    asr_core_model core (
        .pclk(pclk), .conv_req(conv_req), .conv_valid(conv_valid), .conv_data(conv_data),
        .sample(sample), .delay(delay)
    );
    initial forever #25 pclk = ~pclk;
    always @(posedge pclk) begin
        if (precharge_active === 1'b1) n_pre++;
        if (acquire_active === 1'b1) n_acq++;
    end
    function automatic logic [11:0] ba(input logic [9:0] i);
        return {i, 2'b00};
    endfunction
    function automatic logic [31:0] fmt(input logic jf, input logic [11:0] d);
        return jf ? {20'h0, d} : {16'h0, d, 4'h0};
    endfunction
    task automatic tally_and_finish(input logic hung);
        if (hung) n_errors++;
        if (n_errors == 0 && n_tests > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int k;
        k = 0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            k++;
        end while (pready !== 1'b1 && k < 20);
        if (pready !== 1'b1) tally_and_finish(1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [9:0] i, input logic [31:0] d);
        apb(1'b1, ba(i), d);
    endtask
    task automatic rdc(input string nm, input logic [9:0] i, input logic [31:0] e);
        apb(1'b0, ba(i), 32'h0);
        `CHK(nm, e, rd)
    endtask
    task automatic conv(input int pr, input int aq, input int cs, input logic [7:0] ctl);
        int k;
        k = 0;
        wr(`ASR_IDX_PRE, 32'(pr));
        wr(`ASR_IDX_ACQ, 32'(aq));
        sample <= 12'($urandom);
        delay <= 4'($urandom_range(0, 6));
        n_pre = 0;
        n_acq = 0;
        wr(`ASR_IDX_CTRL, {15'h0, 1'b1, 6'(cs), 2'h0, ctl});
        while (conv_valid !== 1'b1 && k < 40000) begin
            @(posedge pclk);
            k++;
        end
        if (conv_valid !== 1'b1) tally_and_finish(1'b1);
        repeat (3) @(posedge pclk);
    endtask
    initial begin
        void'($urandom(18681));
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        foreach (ridx[j]) rdc("reset", ridx[j], 32'h0);
        `CHK("supply", 1'b1, ref_to_supply)
        keep = $urandom;
        wr(`ASR_IDX_PCH, {26'h0, keep[5:0]});
        wr(`ASR_IDX_CAP, {27'h0, keep[10:6]});
        @(negedge pclk);
        `CHK("chan", keep[5:0], input_channel_select)
        `CHK("cap", keep[10:6], extra_capacitance_setting)
        for (j = 0; j < 4; j++) begin
            wr(`ASR_IDX_CTRL, 32'(j) << 8);
            repeat (2) @(negedge pclk);
            `CHK("ref", {j == 3, j == 2, j == 0}, {ref_to_fixed_voltage_reference, ref_to_pin, ref_to_supply})
            `CHK("ref_sel", 2'(j), upper_reference_select)
        end
        apb(1'b0, 12'h004, 32'h0);
        `CHK("unmapped", 33'h100000000, {err, rd})
        apb(1'b0, ba(`ASR_IDX_PCH) | 12'h1, 32'h0);
        `CHK("misaligned", 33'h100000000, {err, rd})
        for (j = 0; j < 5; j++) begin
            wr(`ASR_IDX_CTRL, 32'(j));
            rdc("mode", `ASR_IDX_CTRL, 32'(j));
        end
        wr(`ASR_IDX_CNT, 32'h33);
        wr(`ASR_IDX_ACC, 32'h155);
        s = $urandom_range(0, 6);
        wr(`ASR_IDX_CTRL, {25'h0, 3'(s), 4'h9});
        rdc("cnt_clr", `ASR_IDX_CNT, 32'h0);
        rdc("acc_clr", `ASR_IDX_ACC, 32'h0);
        rdc("clr_bit", `ASR_IDX_CTRL, {25'h0, 3'(s), 4'h1});
        acc = 0;
        for (j = 1; j <= 4; j++) begin
            p = $urandom_range(1, 3);
            q = $urandom_range(1, 3);
            c = $urandom_range(0, 2);
            conv(p, q, c, {j[0], 3'(s), 4'h1});
            acc += sample;
            `CHK("pre", p * 2 * (c + 1), n_pre)
            `CHK("acq", q * 2 * (c + 1), n_acq)
            rdc("res", `ASR_IDX_RES, fmt(j[0], sample));
            rdc("flt", `ASR_IDX_FILTER, 32'(acc >> s));
            rdc("cnt", `ASR_IDX_CNT, 32'(j));
        end
        conv(0, 2, 0, 8'h0);
        `CHK("skip_pre", 0, n_pre)
        conv(0, 0, 0, 8'h0);
        `CHK("skip_acq", 0, n_pre + n_acq)
        conv(1, 0, 0, 8'h0);
        `CHK("acq_dflt", 16384, n_acq)
        conv(8191, 1, 0, 8'h0);
        `CHK("pre_max", 16382, n_pre)
        rdc("cnt_basic", `ASR_IDX_CNT, 32'h4);
        wr(`ASR_IDX_CTRL, {25'h0, 3'(s), 4'hc});
        acc = 0;
        for (j = 0; j < 2; j++) begin
            conv(1, 1, 0, {1'b1, 3'(s), 4'h4});
            acc = acc - (acc >> s) + sample;
            rdc("lpf", `ASR_IDX_FILTER, 32'(16'(acc >> s)));
        end
        wr(`ASR_IDX_STAT, 32'h10);
        wr(`ASR_IDX_RPT, 32'h2);
        wr(`ASR_IDX_CTRL, 32'ha);
        for (j = 1; j <= 2; j++) begin
            conv(1, 1, 0, 8'h2);
            rdc("thr", `ASR_IDX_STAT, j == 2 ? 32'h10 : 32'h0);
        end
        conv(1, 1, 0, 8'h3);
        rdc("restart_cnt", `ASR_IDX_CNT, 32'h1);
        rdc("restart_flt", `ASR_IDX_FILTER, 32'(sample));
        wr(`ASR_IDX_CNT, 32'h5a);
        apb(1'b0, ba(`ASR_IDX_RES), 32'h0);
        keep = rd;
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        rdc("cnt_keep", `ASR_IDX_CNT, 32'h5a);
        rdc("res_keep", `ASR_IDX_RES, keep);
        rdc("chan_rst", `ASR_IDX_PCH, 32'h0);
        tally_and_finish(1'b0);
    end
endmodule
bind asr_adc_sequencer asr_chk chk (
    .pclk(pclk), .presetn(presetn), .upper_reference_select(upper_reference_select),
    .ref_to_fixed_voltage_reference(ref_to_fixed_voltage_reference), .ref_to_pin(ref_to_pin),
    .ref_to_supply(ref_to_supply), .precharge_active(precharge_active), .acquire_active(acquire_active),
    .conv_req(conv_req), .conv_valid(conv_valid)
);
